// file: src/srm_regs.svh
// bit positions and reset values of the status reporting block
// assumes it is included by bare name from the status reporting module only
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH
// operation condition word
`define SRM_OP_CAL 0
`define SRM_OP_WTG 5
`define SRM_OP_CV 8
`define SRM_OP_CCP 10
`define SRM_OP_CCN 11
// questionable condition word
`define SRM_QU_OV 0
`define SRM_QU_OCP 1
`define SRM_QU_FS 2
`define SRM_QU_OT 4
`define SRM_QU_RI 9
`define SRM_QU_UNREG 10
`define SRM_QU_OVLD 14
// standard event latch
`define SRM_SE_OPC 0
`define SRM_SE_QYE 2
`define SRM_SE_DDE 3
`define SRM_SE_EXE 4
`define SRM_SE_CME 5
`define SRM_SE_PON 7
// summary byte and service request mask
`define SRM_SB_ABNORMAL_SUMMARY 3
`define SRM_SB_MAV 4
`define SRM_SB_ESB 5
`define SRM_SB_MSS 6
`define SRM_SB_NORMAL_OPS_SUMMARY 7
// reset values
`define SRM_RISE_RST 16'hFFFF
`define SRM_FALL_RST 16'h0000
`define SRM_MASK_RST 16'h0000
`define SRM_SRE_RST 8'h00
`define SRM_ESR_RST 8'h80
`define SRM_ESE_RST 8'h00
`endif

// file: src/srm_pkg.sv
// types shared by the status reporting block and its surroundings
// assumes the command parser speaks in srm_cmd_t codes
package srm_pkg;
  // operation condition sources
  typedef struct packed {
    logic cal;
    logic awaiting_trigger_flag;
    logic voltage_regulation_flag;
    logic positive_current_limit_flag;
    logic negative_current_limit_flag;
  } srm_normal_ops_summary_in_t;
  // questionable condition sources
  typedef struct packed {
    logic overvoltage_trip_flag;
    logic overcurrent_trip_flag;
    logic fuse_blown_flag;
    logic overtemperature_trip_flag;
    logic external_inhibit_flag;
    logic unregulated_flag;
    logic low_range_overflow_flag;
  } srm_abnormal_summary_in_t;
  // standard event pulses
  typedef struct packed {
    logic operation_complete_flag;
    logic query_error_flag;
    logic device_specific_error_flag;
    logic execution_error_flag;
    logic command_error_flag;
  } srm_std_in_t;
  // register commands
  typedef enum logic [4:0] {
    SRM_CMD_NONE = 5'h00, SRM_CMD_RD_OP_COND = 5'h01,
    SRM_CMD_RD_OP_RISE = 5'h02, SRM_CMD_WR_OP_RISE = 5'h03,
    SRM_CMD_RD_OP_FALL = 5'h04, SRM_CMD_WR_OP_FALL = 5'h05,
    SRM_CMD_RD_OP_EVENT = 5'h06, SRM_CMD_RD_OP_MASK = 5'h07,
    SRM_CMD_WR_OP_MASK = 5'h08, SRM_CMD_RD_QU_COND = 5'h09,
    SRM_CMD_RD_QU_RISE = 5'h0A, SRM_CMD_WR_QU_RISE = 5'h0B,
    SRM_CMD_RD_QU_FALL = 5'h0C, SRM_CMD_WR_QU_FALL = 5'h0D,
    SRM_CMD_RD_QU_EVENT = 5'h0E, SRM_CMD_RD_QU_MASK = 5'h0F,
    SRM_CMD_WR_QU_MASK = 5'h10, SRM_CMD_RD_ESR = 5'h11,
    SRM_CMD_RD_ESE = 5'h12, SRM_CMD_WR_ESE = 5'h13,
    SRM_CMD_RD_STB = 5'h14, SRM_CMD_RD_SRE = 5'h15,
    SRM_CMD_WR_SRE = 5'h16, SRM_CMD_SERIAL_POLL = 5'h17
  } srm_cmd_t;
  // one command with its write value
  typedef struct packed {
    logic valid;
    srm_cmd_t code;
    logic [15:0] wdata;
  } srm_req_t;
  // read answer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } srm_resp_t;
endpackage : srm_pkg

// file: src/srm_status.sv
// status reporting structure: condition, filters, latches, masks,
// summary byte and service request line
// assumes a command parser on sys_clk drives req and takes resp
// Notes on behaviour
// RULE_01 - operation bits 0,5,8: calibrating, trigger wait, voltage
// RULE_02 - operation bits 10,11: positive, negative current limit
// RULE_03 - questionable bits 0,1,2: overvoltage, overcurrent, fuse
// RULE_04 - questionable bits 4,9: overtemperature, inhibit
// RULE_05 - questionable bits 10,14: unregulated, range overflow
// RULE_06 - standard event bits 0,2,3,4,5 as listed
// RULE_07 - power-up sets standard event bit 7
// RULE_08 - summary bits 3,4,5: abnormal, message, event
// RULE_09 - bit 6 master or request; bit 7 operation
// RULE_10 - condition words live, read only, unlatched
// RULE_11 - rise and fall filters readable, writable per bit
// RULE_12 - filtered transitions latch; read returns then clears
// RULE_13 - enable masks select latched bits into summary
// RULE_14 - masked operation events OR into bit 7
// RULE_15 - masked questionable events OR into bit 3
// RULE_16 - event mask command gates standard event summary
// RULE_17 - power-on clear setting empties event mask
// RULE_18 - event latch query returns and clears it
// RULE_19 - power-up reaches summary only via mask bit 7
// RULE_20 - summary requests service only when mask bit set
// RULE_21 - enabled event raises service request line
// RULE_22 - master summary live; status query clears nothing
// RULE_23 - request flag latched; serial poll clears it only
// RULE_24 - message bit set while output queue nonempty
// RULE_25 - reading event latch drops its summary bit
// RULE_26 - new event beats same-cycle clear
// RULE_27 - reset clears latches except event bit 7, loads default masks
`include "srm_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module srm_status (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // monitored circuit levels, asynchronous
  input wire srm_pkg::srm_normal_ops_summary_in_t normal_ops_summary_in,
  input wire srm_pkg::srm_abnormal_summary_in_t abnormal_summary_in,
  // same-clock events and levels
  input wire srm_pkg::srm_std_in_t std_in,
  input wire logic queue_not_empty,
  input wire logic power_on_clear,
  input wire logic [7:0] saved_event_mask,
  // command port
  input wire srm_pkg::srm_req_t req,
  output var srm_pkg::srm_resp_t resp,
  // service request line toward the controller
  output logic srq_active
);

  // maps the live operation sources onto their word
  function automatic logic [15:0] normal_ops_summary_word(input logic [4:0] b);
    logic [15:0] w;
    w = 16'h0000;
    w[`SRM_OP_CAL] = b[4]; // RULE_01
    w[`SRM_OP_WTG] = b[3]; // RULE_01
    w[`SRM_OP_CV] = b[2]; // RULE_01
    w[`SRM_OP_CCP] = b[1]; // RULE_02
    w[`SRM_OP_CCN] = b[0]; // RULE_02
    return w;
  endfunction : normal_ops_summary_word

  // maps the live questionable sources onto their word
  function automatic logic [15:0] abnormal_summary_word(input logic [6:0] b);
    logic [15:0] w;
    w = 16'h0000;
    w[`SRM_QU_OV] = b[6]; // RULE_03
    w[`SRM_QU_OCP] = b[5]; // RULE_03
    w[`SRM_QU_FS] = b[4]; // RULE_03
    w[`SRM_QU_OT] = b[3]; // RULE_04
    w[`SRM_QU_RI] = b[2]; // RULE_04
    w[`SRM_QU_UNREG] = b[1]; // RULE_05
    w[`SRM_QU_OVLD] = b[0]; // RULE_05
    return w;
  endfunction : abnormal_summary_word

  // per-bit transitions that pass the rise or fall filter
  function automatic logic [15:0] passed(input logic [15:0] now_w,
      input logic [15:0] old_w, input logic [15:0] rise,
      input logic [15:0] fall);
    return (now_w & ~old_w & rise) | (~now_w & old_w & fall); // RULE_11
  endfunction : passed

  // --- input synchroniser -----------------------------------------
  logic [11:0] raw_bits; // all monitored levels
  logic [11:0] sync1; // first stage, read only by sync2
  logic [11:0] sync2;
  logic [11:0] sync3;
  logic [11:0] live; // accepted level
  logic [11:0] next_live;
  logic [11:0] agree;

  assign raw_bits = {normal_ops_summary_in, abnormal_summary_in};

  // a bit is accepted only when stages two and three agree, so a
  // level caught mid-change never makes a false transition
  always_comb begin
    agree = ~(sync2 ^ sync3);
    next_live = (agree & sync3) | (~agree & live);
  end

  // synchroniser chain
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
      sync3 <= 12'h000;
      live <= 12'h000;
    end else begin
      sync1 <= raw_bits;
      sync2 <= sync1;
      sync3 <= sync2;
      live <= next_live;
    end
  end

  // --- condition words and transitions ----------------------------
  logic [15:0] op_cond; // live, read only
  logic [15:0] qu_cond;
  logic [15:0] op_cond_next;
  logic [15:0] qu_cond_next;
  logic [15:0] op_trans;
  logic [15:0] qu_trans;

  // condition words follow the accepted levels with no latching
  always_comb begin
    op_cond = normal_ops_summary_word(live[11:7]); // RULE_10
    qu_cond = abnormal_summary_word(live[6:0]); // RULE_10
    op_cond_next = normal_ops_summary_word(next_live[11:7]);
    qu_cond_next = abnormal_summary_word(next_live[6:0]);
  end

  // --- command decode ---------------------------------------------
  logic cmd_on;
  srm_pkg::srm_cmd_t cmd;

  assign cmd_on = req.valid;
  assign cmd = req.code;

  // --- filters, latches and masks ---------------------------------
  logic [15:0] op_rise;
  logic [15:0] op_fall;
  logic [15:0] op_event;
  logic [15:0] op_mask;
  logic [15:0] qu_rise;
  logic [15:0] qu_fall;
  logic [15:0] qu_event;
  logic [15:0] qu_mask;
  logic [7:0] std_event;
  logic [7:0] std_mask;
  logic [7:0] sre_mask;
  logic mask_loaded; // power-up load of the event mask done
  logic [15:0] next_op_rise;
  logic [15:0] next_op_fall;
  logic [15:0] next_op_event;
  logic [15:0] next_op_mask;
  logic [15:0] next_qu_rise;
  logic [15:0] next_qu_fall;
  logic [15:0] next_qu_event;
  logic [15:0] next_qu_mask;
  logic [7:0] next_std_event;
  logic [7:0] next_std_mask;
  logic [7:0] next_sre_mask;
  logic [7:0] std_new; // this cycle's standard events

  // transitions are judged against the word about to be accepted,
  // so the latch and the condition word move on the same edge
  always_comb begin
    op_trans = passed(op_cond_next, op_cond, op_rise, op_fall);
    qu_trans = passed(qu_cond_next, qu_cond, qu_rise, qu_fall);
    std_new = 8'h00;
    std_new[`SRM_SE_OPC] = std_in.operation_complete_flag; // RULE_06
    std_new[`SRM_SE_QYE] = std_in.query_error_flag; // RULE_06
    std_new[`SRM_SE_DDE] = std_in.device_specific_error_flag; // RULE_06
    std_new[`SRM_SE_EXE] = std_in.execution_error_flag; // RULE_06
    std_new[`SRM_SE_CME] = std_in.command_error_flag; // RULE_06
  end

  // next values of all programmable and latched state
  always_comb begin
    next_op_rise = op_rise;
    next_op_fall = op_fall;
    next_op_mask = op_mask;
    next_qu_rise = qu_rise;
    next_qu_fall = qu_fall;
    next_qu_mask = qu_mask;
    next_std_mask = std_mask;
    next_sre_mask = sre_mask;
    next_op_event = op_event;
    next_qu_event = qu_event;
    next_std_event = std_event;
    // clearing reads come first, so the OR below can win
    if (cmd_on && cmd == srm_pkg::SRM_CMD_RD_OP_EVENT) begin
      next_op_event = 16'h0000; // RULE_12 RULE_25
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_RD_QU_EVENT) begin
      next_qu_event = 16'h0000; // RULE_12 RULE_25
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_RD_ESR) begin
      next_std_event = 8'h00; // RULE_18
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_WR_OP_RISE) begin
      next_op_rise = req.wdata; // RULE_11
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_WR_OP_FALL) begin
      next_op_fall = req.wdata; // RULE_11
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_WR_OP_MASK) begin
      next_op_mask = req.wdata; // RULE_13
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_WR_QU_RISE) begin
      next_qu_rise = req.wdata; // RULE_11
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_WR_QU_FALL) begin
      next_qu_fall = req.wdata; // RULE_11
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_WR_QU_MASK) begin
      next_qu_mask = req.wdata; // RULE_13
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_WR_ESE) begin
      next_std_mask = req.wdata[7:0]; // RULE_16
    end else if (cmd_on && cmd == srm_pkg::SRM_CMD_WR_SRE) begin
      // the master bit has no enable of its own
      next_sre_mask = req.wdata[7:0] & 8'hBF; // RULE_20
    end
    // first cycle after power-up: clear or restore the event mask;
    // a write in that same cycle loses, the restore is the power-up
    if (!mask_loaded) begin
      next_std_mask = power_on_clear ? `SRM_ESE_RST : saved_event_mask; // RULE_17
    end
    // new events are ORed after any clear and are never lost
    next_op_event = next_op_event | op_trans; // RULE_12 RULE_26
    next_qu_event = next_qu_event | qu_trans; // RULE_12 RULE_26
    next_std_event = next_std_event | std_new; // RULE_26
  end

  // register stage of filters, latches and masks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_rise <= `SRM_RISE_RST; // RULE_27
      op_fall <= `SRM_FALL_RST;
      op_mask <= `SRM_MASK_RST;
      qu_rise <= `SRM_RISE_RST;
      qu_fall <= `SRM_FALL_RST;
      qu_mask <= `SRM_MASK_RST;
      sre_mask <= `SRM_SRE_RST;
      std_mask <= `SRM_ESE_RST;
      op_event <= 16'h0000; // RULE_27
      qu_event <= 16'h0000;
      // power-up is the only source of bit 7
      std_event <= `SRM_ESR_RST; // RULE_07
      mask_loaded <= 1'b0;
    end else begin
      op_rise <= next_op_rise;
      op_fall <= next_op_fall;
      op_mask <= next_op_mask;
      qu_rise <= next_qu_rise;
      qu_fall <= next_qu_fall;
      qu_mask <= next_qu_mask;
      sre_mask <= next_sre_mask;
      std_mask <= next_std_mask;
      op_event <= next_op_event;
      qu_event <= next_qu_event;
      std_event <= next_std_event;
      mask_loaded <= 1'b1;
    end
  end

  // --- summary byte -----------------------------------------------
  logic op_summary;
  logic qu_summary;
  logic esb_summary;
  logic [7:0] stb_base; // summary byte without bit 6
  logic master_summary; // live master summary
  logic mss_prev;
  logic service_request_flag; // latched request flag
  logic next_mss_prev;
  logic next_rqs;
  logic poll_now;

  // live ORs of masked latches; a clearing read drops them at once
  always_comb begin
    op_summary = |(op_event & op_mask); // RULE_13 RULE_14 RULE_25
    qu_summary = |(qu_event & qu_mask); // RULE_13 RULE_15 RULE_25
    esb_summary = |(std_event & std_mask); // RULE_16 RULE_19
    stb_base = 8'h00;
    stb_base[`SRM_SB_ABNORMAL_SUMMARY] = qu_summary; // RULE_08
    stb_base[`SRM_SB_MAV] = queue_not_empty; // RULE_08 RULE_24
    stb_base[`SRM_SB_ESB] = esb_summary; // RULE_08
    stb_base[`SRM_SB_NORMAL_OPS_SUMMARY] = op_summary; // RULE_09
    master_summary = |(stb_base & sre_mask); // RULE_20 RULE_22
  end

  // request flag: set by a new reason, cleared only by a poll;
  // a fresh reason in the poll cycle keeps the flag set
  always_comb begin
    poll_now = cmd_on && cmd == srm_pkg::SRM_CMD_SERIAL_POLL;
    next_mss_prev = master_summary;
    next_rqs = service_request_flag;
    if (poll_now) begin
      next_rqs = 1'b0; // RULE_23
    end
    if (master_summary && !mss_prev) begin
      next_rqs = 1'b1; // RULE_21 RULE_23
    end
  end

  // register stage of the request flag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mss_prev <= 1'b0;
      service_request_flag <= 1'b0;
    end else begin
      mss_prev <= next_mss_prev;
      service_request_flag <= next_rqs;
    end
  end

  // the line follows the latched flag
  assign srq_active = service_request_flag; // RULE_21

  // --- read answers -----------------------------------------------
  srm_pkg::srm_resp_t next_resp;

  // read mux; writes and idle cycles give no answer
  always_comb begin
    next_resp.valid = cmd_on;
    next_resp.data = 16'h0000;
    if (!cmd_on) begin
      next_resp.valid = 1'b0;
    end else if (cmd == srm_pkg::SRM_CMD_RD_OP_COND) begin
      next_resp.data = op_cond; // RULE_10
    end else if (cmd == srm_pkg::SRM_CMD_RD_OP_RISE) begin
      next_resp.data = op_rise; // RULE_11
    end else if (cmd == srm_pkg::SRM_CMD_RD_OP_FALL) begin
      next_resp.data = op_fall;
    end else if (cmd == srm_pkg::SRM_CMD_RD_OP_EVENT) begin
      next_resp.data = op_event; // RULE_12
    end else if (cmd == srm_pkg::SRM_CMD_RD_OP_MASK) begin
      next_resp.data = op_mask; // RULE_13
    end else if (cmd == srm_pkg::SRM_CMD_RD_QU_COND) begin
      next_resp.data = qu_cond; // RULE_10
    end else if (cmd == srm_pkg::SRM_CMD_RD_QU_RISE) begin
      next_resp.data = qu_rise;
    end else if (cmd == srm_pkg::SRM_CMD_RD_QU_FALL) begin
      next_resp.data = qu_fall;
    end else if (cmd == srm_pkg::SRM_CMD_RD_QU_EVENT) begin
      next_resp.data = qu_event; // RULE_12
    end else if (cmd == srm_pkg::SRM_CMD_RD_QU_MASK) begin
      next_resp.data = qu_mask;
    end else if (cmd == srm_pkg::SRM_CMD_RD_ESR) begin
      next_resp.data = {8'h00, std_event}; // RULE_18
    end else if (cmd == srm_pkg::SRM_CMD_RD_ESE) begin
      next_resp.data = {8'h00, std_mask};
    end else if (cmd == srm_pkg::SRM_CMD_RD_STB) begin
      // live master bit, nothing is cleared
      next_resp.data = {8'h00, stb_base | {1'b0, master_summary, 6'h00}}; // RULE_09 RULE_22
    end else if (cmd == srm_pkg::SRM_CMD_RD_SRE) begin
      next_resp.data = {8'h00, sre_mask};
    end else if (cmd == srm_pkg::SRM_CMD_SERIAL_POLL) begin
      next_resp.data = {8'h00, stb_base | {1'b0, service_request_flag, 6'h00}}; // RULE_09 RULE_23
    end else begin
      next_resp.valid = 1'b0; // writes answer nothing
    end
  end

  // registered answer, one cycle after the command
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resp <= '0;
    end else begin
      resp <= next_resp;
    end
  end

  // --- assertions -------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_rise_latches;
    (op_trans[`SRM_OP_CCP]) |=> op_event[`SRM_OP_CCP];
  endproperty
  a_rise_latches: assert property (p_rise_latches) // RULE_12
    else $error("filtered transition not latched");

  property p_read_clears;
    (cmd_on && cmd == srm_pkg::SRM_CMD_RD_QU_EVENT && qu_trans == 16'h0000)
      |=> qu_event == 16'h0000 && !qu_summary;
  endproperty
  a_read_clears: assert property (p_read_clears) // RULE_25
    else $error("event read did not clear latch and summary");

  property p_set_wins;
    (cmd_on && cmd == srm_pkg::SRM_CMD_RD_OP_EVENT && op_trans != 16'h0000)
      |=> (op_event & $past(op_trans)) == $past(op_trans);
  endproperty
  a_set_wins: assert property (p_set_wins) // RULE_26
    else $error("event lost in clearing cycle");

  property p_esr_query;
    (cmd_on && cmd == srm_pkg::SRM_CMD_RD_ESR && std_new == 8'h00)
      |=> resp.valid && resp.data[7:0] == $past(std_event) && std_event == 8'h00;
  endproperty
  a_esr_query: assert property (p_esr_query) // RULE_18
    else $error("standard event query wrong");

  property p_stb_query;
    (cmd_on && cmd == srm_pkg::SRM_CMD_RD_STB)
      |=> resp.data[`SRM_SB_MSS] == $past(master_summary) && service_request_flag == $past(next_rqs);
  endproperty
  a_stb_query: assert property (p_stb_query) // RULE_22
    else $error("status query answer wrong");

  property p_srq_raise;
    (master_summary && !mss_prev) |=> srq_active [*1] ##0 resp.valid == $past(cmd_on
      && cmd != srm_pkg::SRM_CMD_NONE && next_resp.valid);
  endproperty
  a_srq_raise: assert property (p_srq_raise) // RULE_21
    else $error("service request not raised");

  property p_poll_clears;
    (poll_now && !(master_summary && !mss_prev) && service_request_flag)
      |=> !srq_active && resp.data[`SRM_SB_MSS];
  endproperty
  a_poll_clears: assert property (p_poll_clears) // RULE_23
    else $error("serial poll did not clear request");

  property p_pon_gated;
    (std_event == 8'h80 && !std_mask[`SRM_SE_PON]) |-> !esb_summary;
  endproperty
  a_pon_gated: assert property (p_pon_gated) // RULE_19
    else $error("power-up reached summary while masked");

  property p_summary_masked;
    (sre_mask == 8'h00) |-> !master_summary ##1 (sre_mask != 8'h00 || !srq_active
      || $past(srq_active));
  endproperty
  a_summary_masked: assert property (p_summary_masked) // RULE_20
    else $error("masked summary requested service");

endmodule : srm_status

`default_nettype wire

// file: bench/srm_ctrl_model.sv
// controller model: sends queries, writes and serial polls to the block
// assumes commands launch just after the rising edge, one per cycle
`timescale 1ns/10ps
`default_nettype none

module srm_ctrl_model (
  // clock from the bench
  input wire logic sys_clk,
  // command toward the block
  output var srm_pkg::srm_req_t req
);
  // quiet port at time zero
  initial begin
    req = '0;
  end
  // hold one command across exactly one taking edge
  task automatic issue(input srm_pkg::srm_cmd_t code, input logic [15:0] wdata);
    req = '{valid: 1'b1, code: code, wdata: wdata};
    @(posedge sys_clk);
    #1;
  endtask : issue
  // release the port; stale write data is inverted so it never looks valid
  task automatic idle();
    req.valid = 1'b0;
    req.code = srm_pkg::SRM_CMD_NONE;
    req.wdata = ~req.wdata;
    @(posedge sys_clk);
    #1;
  endtask : idle
endmodule : srm_ctrl_model
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the status reporting block
// assumes reads answer on the taking edge, one cycle after the command
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_top;
  // design stimulus, all defined at time zero
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  srm_pkg::srm_normal_ops_summary_in_t normal_ops_summary_in = '0;
  srm_pkg::srm_abnormal_summary_in_t abnormal_summary_in = '0;
  srm_pkg::srm_std_in_t std_in = '0;
  logic queue_not_empty = 1'b0;
  logic power_on_clear = 1'b1;
  logic [7:0] saved_event_mask = 8'h00;
  srm_pkg::srm_req_t req;
  srm_pkg::srm_resp_t resp;
  logic srq_active;
  // scoreboard
  typedef struct {string nm; logic [15:0] d;} srm_exp_t;
  srm_exp_t exp_q[$];
  srm_exp_t mon_e;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] rnd = 32'h63eb_8fc0;
  logic [15:0] d;
  // writable registers, their reset values and bit position tables
  srm_pkg::srm_cmd_t wtab[8] = '{srm_pkg::SRM_CMD_WR_OP_RISE, srm_pkg::SRM_CMD_WR_OP_FALL,
    srm_pkg::SRM_CMD_WR_OP_MASK, srm_pkg::SRM_CMD_WR_QU_RISE, srm_pkg::SRM_CMD_WR_QU_FALL,
    srm_pkg::SRM_CMD_WR_QU_MASK, srm_pkg::SRM_CMD_WR_ESE, srm_pkg::SRM_CMD_WR_SRE};
  logic [15:0] rst[8] = '{16'hffff, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000,
    16'h0000, 16'h0000};
  int opos[5] = '{0, 5, 8, 10, 11};
  int qpos[7] = '{0, 1, 2, 4, 9, 10, 14};

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  srm_status u_srm_status (.sys_clk(sys_clk), .reset_n(reset_n), .normal_ops_summary_in(normal_ops_summary_in),
    .abnormal_summary_in(abnormal_summary_in), .std_in(std_in), .queue_not_empty(queue_not_empty),
    .power_on_clear(power_on_clear), .saved_event_mask(saved_event_mask), .req(req),
    .resp(resp), .srq_active(srq_active));
  srm_ctrl_model u_srm_ctrl_model (.sys_clk(sys_clk), .req(req));

  // pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  // release the port, then let the synchronisers settle
  task automatic settle();
    u_srm_ctrl_model.idle();
    cyc(6);
  endtask : settle
  task automatic rd(input string nm, input srm_pkg::srm_cmd_t c, input logic [15:0] e);
    exp_q.push_back('{nm, e});
    u_srm_ctrl_model.issue(c, 16'h0000);
  endtask : rd
  task automatic wr(input srm_pkg::srm_cmd_t c, input logic [15:0] v);
    u_srm_ctrl_model.issue(c, v);
  endtask : wr
  task automatic do_reset();
    reset_n = 1'b0;
    cyc(5);
    reset_n = 1'b1;
    cyc(2);
  endtask : do_reset
  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // answers are compared once settled, oldest note first
  always @(posedge sys_clk) begin
    #2;
    if (resp.valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK("spare answer", 1'b0, 1'b1)
      else begin
        mon_e = exp_q.pop_front();
        `CHK(mon_e.nm, mon_e.d, resp.data)
      end
    end
  end

  // hang guard
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial begin
    #1;
    do_reset();
    // reset values, then random write and back-to-back readback
    for (int i = 0; i < 8; i++) rd("reset value", srm_pkg::srm_cmd_t'(wtab[i] - 1), rst[i]);
    rd("powerup latch", srm_pkg::SRM_CMD_RD_ESR, 16'h0080);
    rd("latch after query", srm_pkg::SRM_CMD_RD_ESR, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr_next(rnd);
      d = rnd[15:0] & (i == 7 ? 16'h00bf : (i == 6 ? 16'h00ff : 16'hffff));
      wr(wtab[i], rnd[15:0]);
      rd("readback", srm_pkg::srm_cmd_t'(wtab[i] - 1), d);
    end
    for (int i = 0; i < 8; i++) wr(wtab[i], rst[i]);
    // each condition source lands on its own bit
    for (int j = 0; j < 5; j++) begin
      normal_ops_summary_in = 5'(1 << (4 - j));
      settle();
      rd("op condition", srm_pkg::SRM_CMD_RD_OP_COND, 16'(1 << opos[j]));
    end
    for (int j = 0; j < 7; j++) begin
      abnormal_summary_in = 7'(1 << (6 - j));
      settle();
      rd("qu condition", srm_pkg::SRM_CMD_RD_QU_COND, 16'(1 << qpos[j]));
    end
    normal_ops_summary_in = '0;
    abnormal_summary_in = '0;
    settle();
    rd("op condition", srm_pkg::SRM_CMD_RD_OP_COND, 16'h0000);
    rd("op event", srm_pkg::SRM_CMD_RD_OP_EVENT, 16'h0d21);
    rd("op event", srm_pkg::SRM_CMD_RD_OP_EVENT, 16'h0000);
    rd("qu event", srm_pkg::SRM_CMD_RD_QU_EVENT, 16'h4617);
    // enabled current limit raises the service line
    wr(srm_pkg::SRM_CMD_WR_OP_MASK, 16'h0400);
    wr(srm_pkg::SRM_CMD_WR_SRE, 16'h0080);
    normal_ops_summary_in.positive_current_limit_flag = 1'b1;
    settle();
    `CHK("service line", 1'b1, srq_active)
    rd("summary", srm_pkg::SRM_CMD_RD_STB, 16'h00c0);
    rd("poll", srm_pkg::SRM_CMD_SERIAL_POLL, 16'h00c0);
    rd("summary", srm_pkg::SRM_CMD_RD_STB, 16'h00c0);
    rd("poll again", srm_pkg::SRM_CMD_SERIAL_POLL, 16'h0080);
    rd("op event", srm_pkg::SRM_CMD_RD_OP_EVENT, 16'h0400);
    rd("summary", srm_pkg::SRM_CMD_RD_STB, 16'h0000);
    settle();
    `CHK("service line", 1'b0, srq_active)
    // falling edge passes only through the fall filter
    wr(srm_pkg::SRM_CMD_WR_OP_FALL, 16'h0400);
    normal_ops_summary_in.positive_current_limit_flag = 1'b0;
    settle();
    `CHK("service line", 1'b1, srq_active)
    rd("op event", srm_pkg::SRM_CMD_RD_OP_EVENT, 16'h0400);
    // the event read has already dropped the operation summary, only the flag remains
    rd("poll", srm_pkg::SRM_CMD_SERIAL_POLL, 16'h0040);
    // abnormal summary without its service enable
    wr(srm_pkg::SRM_CMD_WR_SRE, 16'h0000);
    wr(srm_pkg::SRM_CMD_WR_QU_MASK, 16'h0001);
    wr(srm_pkg::SRM_CMD_WR_ESE, 16'h0001);
    abnormal_summary_in.overvoltage_trip_flag = 1'b1;
    queue_not_empty = 1'b1;
    settle();
    `CHK("service line", 1'b0, srq_active)
    for (int k = 0; k < 5; k++) begin
      std_in = 5'(1 << k);
      cyc(1);
    end
    std_in = '0;
    rd("summary", srm_pkg::SRM_CMD_RD_STB, 16'h0038);
    rd("std latch", srm_pkg::SRM_CMD_RD_ESR, 16'h003d);
    rd("summary", srm_pkg::SRM_CMD_RD_STB, 16'h0018);
    // second reset keeps the saved event mask; power-up reaches the line
    abnormal_summary_in = '0;
    queue_not_empty = 1'b0;
    power_on_clear = 1'b0;
    saved_event_mask = 8'h80;
    settle();
    do_reset();
    wr(srm_pkg::SRM_CMD_WR_SRE, 16'h0020);
    settle();
    `CHK("service line", 1'b1, srq_active)
    rd("kept mask", srm_pkg::SRM_CMD_RD_ESE, 16'h0080);
    rd("summary", srm_pkg::SRM_CMD_RD_STB, 16'h0060);
    rd("powerup latch", srm_pkg::SRM_CMD_RD_ESR, 16'h0080);
    settle();
    `CHK("pending answers", 0, exp_q.size())
    conclude();
  end
endmodule : tb_top
`default_nettype wire
